//--- common/cwd_pkg.sv
// Package of constants, layouts and types for the configuration word decoder
package cwd_pkg;

  // Wishbone register offsets (byte addresses)
  localparam logic [7:0] CWD_OFS_CFG0    = 8'h00;
  localparam logic [7:0] CWD_OFS_CFG2    = 8'h04;
  localparam logic [7:0] CWD_OFS_PROT    = 8'h08;
  localparam logic [7:0] CWD_OFS_CLK     = 8'h0c;
  localparam logic [7:0] CWD_OFS_RTCFG   = 8'h10;
  localparam logic [7:0] CWD_OFS_STATUS  = 8'h14;

  // Word zero field positions
  localparam int CWD_PWP_LSB      = 12;
  localparam int CWD_PWP_W        = 8;
  localparam int CWD_CHSEL_LSB    = 3;
  localparam int CWD_BSCAN_BIT    = 2;
  localparam int CWD_DBG_LSB      = 0;
  localparam int CWD_RSV0_LSB     = 5;
  localparam int CWD_RSV0_W       = 7;

  // Clock word field positions
  localparam int CWD_DSBOR_BIT    = 23;
  localparam int CWD_RSV22_BIT    = 22;
  localparam int CWD_VBBOR_BIT    = 21;
  localparam int CWD_BOR_BIT      = 20;
  localparam int CWD_RSV19_BIT    = 19;
  localparam int CWD_ODIV_LSB     = 16;
  localparam int CWD_UPLLDIS_BIT  = 15;
  localparam int CWD_UIDIV_LSB    = 8;
  localparam int CWD_PLLSRC_BIT   = 7;
  localparam int CWD_PLLMUL_LSB   = 4;

  // Protection geometry
  localparam logic [7:0]  CWD_PWP_OFF     = 8'hff;
  localparam logic [7:0]  CWD_PWP_MIN_OK  = 8'hbf;
  localparam logic [31:0] CWD_PFM_BASE    = 32'hbd00_0000;
  localparam logic [31:0] CWD_PAGE_BYTES  = 32'h0000_1000;
  localparam logic [1:0]  CWD_DBG_FORCED  = 2'h3;

  // Reset value of latched words before sampling, and read data of unmapped offsets
  localparam logic [31:0] CWD_WORD_RST    = 32'hffff_ffff;
  localparam logic [31:0] CWD_BUS_UNMAP   = 32'h0000_0000;

  // Decoded settings
  typedef struct packed {
    logic [7:0]  prot_pages;
    logic        prot_on;
    logic        pwp_reserved;
    logic [31:0] prot_top;
    logic [3:0]  pin_pair_onehot;
    logic        bscan_en;
    logic        dbg_en;
    logic [1:0]  dbg_field;
    logic        dsbor_en;
    logic        vbbor_en;
    logic        bor_en;
    logic [8:0]  odiv;
    logic        usb_pll_on;
    logic [3:0]  usb_idiv;
    logic        pll_src_frc;
    logic [4:0]  pll_mul;
    logic        rsv_ok;
  } cwd_cfg_t;

  // Configuration storage side
  typedef struct packed {
    logic [31:0] word0;
    logic [31:0] word2;
    logic        code_protect;
  } cwd_store_t;

endpackage : cwd_pkg

//--- logic/cwd_field_dec.sv
// Field decoder from raw configuration words to settings
module cwd_field_dec (
  // Raw words
  input  wire cwd_pkg::cwd_store_t store_i,
  // Decoded
  output cwd_pkg::cwd_cfg_t        cfg_o
);

  function automatic logic [8:0] cwd_odiv(input logic [2:0] c);
    if (c == 3'h7) begin
      cwd_odiv = 9'h100;
    end else begin
      cwd_odiv = 9'(9'h001 << c);
    end
  endfunction : cwd_odiv

  function automatic logic [3:0] cwd_idiv(input logic [2:0] c);
    case (c)
      3'h6:    cwd_idiv = 4'ha;
      3'h7:    cwd_idiv = 4'hc;
      default: cwd_idiv = 4'(c) + 4'h1;
    endcase
  endfunction : cwd_idiv

  function automatic logic [4:0] cwd_mul(input logic [2:0] c);
    case (c)
      3'h7:    cwd_mul = 5'h18;
      // Code zero unlisted; treated as lowest factor
      3'h0:    cwd_mul = 5'h10;
      default: cwd_mul = 5'h0f + 5'(c);
    endcase
  endfunction : cwd_mul

  logic [7:0] page_write_protect_count;
  logic [7:0] pages;
  logic [1:0] chsel;
  logic [1:0] dbg;

  always_comb begin
    page_write_protect_count   = store_i.word0[cwd_pkg::CWD_PWP_LSB +: cwd_pkg::CWD_PWP_W];
    chsel = store_i.word0[cwd_pkg::CWD_CHSEL_LSB +: 2];
    pages = ~page_write_protect_count;
    cfg_o = '0;
    cfg_o.prot_on      = (page_write_protect_count != cwd_pkg::CWD_PWP_OFF);
    cfg_o.pwp_reserved = (page_write_protect_count < cwd_pkg::CWD_PWP_MIN_OK);
    cfg_o.prot_pages   = cfg_o.pwp_reserved ? 8'h00 : pages;
    cfg_o.prot_top     = cwd_pkg::CWD_PFM_BASE + 32'(cfg_o.prot_pages) * cwd_pkg::CWD_PAGE_BYTES - 32'h1;
    cfg_o.pin_pair_onehot = 4'(4'h8 >> chsel);
    cfg_o.bscan_en = store_i.word0[cwd_pkg::CWD_BSCAN_BIT];
    dbg = store_i.code_protect ? cwd_pkg::CWD_DBG_FORCED : store_i.word0[cwd_pkg::CWD_DBG_LSB +: 2];
    cfg_o.dbg_field = dbg;
    cfg_o.dbg_en = ~dbg[1];
    cfg_o.dsbor_en = store_i.word2[cwd_pkg::CWD_DSBOR_BIT];
    cfg_o.vbbor_en = store_i.word2[cwd_pkg::CWD_VBBOR_BIT];
    cfg_o.bor_en = store_i.word2[cwd_pkg::CWD_BOR_BIT];
    cfg_o.odiv = cwd_odiv(store_i.word2[cwd_pkg::CWD_ODIV_LSB +: 3]);
    cfg_o.usb_pll_on = ~store_i.word2[cwd_pkg::CWD_UPLLDIS_BIT];
    cfg_o.usb_idiv = cwd_idiv(store_i.word2[cwd_pkg::CWD_UIDIV_LSB +: 3]);
    cfg_o.pll_src_frc = store_i.word2[cwd_pkg::CWD_PLLSRC_BIT];
    cfg_o.pll_mul = cwd_mul(store_i.word2[cwd_pkg::CWD_PLLMUL_LSB +: 3]);
    cfg_o.rsv_ok = (&store_i.word0[cwd_pkg::CWD_RSV0_LSB +: cwd_pkg::CWD_RSV0_W])
                 & store_i.word2[cwd_pkg::CWD_RSV22_BIT] & store_i.word2[cwd_pkg::CWD_RSV19_BIT];
  end

endmodule : cwd_field_dec

//--- logic/cwd_top.sv
// Configuration word decoder top with Wishbone register view
// Notes on behaviour
// - Write-protect field is ones complement of protected page count; all ones disables.
// - Each step below all ones protects one more page upward.
// - Largest region at code bf; lower codes are reserved.
// - Protected pages cannot be modified while code runs.
// - Channel code selects programming pin pair one to four, code 11 is one.
// - Boundary-scan bit enables port and is copied to runtime control.
// - Debugger disabled when upper debug bit is one.
// - Code protection forces debug field to 11.
// - Deep-sleep brownout bit keeps detection in deep sleep.
// - Battery brownout bit keeps detection on backup supply.
// - Main brownout bit enables brownout reset.
// - Output divisor codes divide by 1 to 64, and 256.
// - USB PLL bit high disables and bypasses it.
// - PLL input bit selects fast RC when one, primary otherwise.
// - Multiplier codes give 16 to 21, and 24.
//
// The register offsets and the Wishbone interface to the registers were decided locally.
module cwd_top (
  // Clock and reset
  input  wire logic                mclk_i,
  input  wire logic                rst_n_i,
  // Configuration storage
  input  wire cwd_pkg::cwd_store_t store_i,
  input  wire logic                store_valid_i,
  // Program memory write attempts
  input  wire logic                pfm_wr_req_i,
  input  wire logic [31:0]         pfm_wr_addr_i,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  // Decoded settings
  output logic                     loaded_o,
  output logic                     pfm_wr_block_o,
  output logic [3:0]               prog_pin_pair_o,
  output logic                     boundary_scan_enable_o,
  output logic                     debug_enable_o,
  output logic                     deep_sleep_brownout_enable_o,
  output logic                     battery_brownout_enable_o,
  output logic                     brownout_reset_enable_o,
  output logic [8:0]               sys_pll_output_divisor_o,
  output logic                     usb_pll_enable_o,
  output logic [3:0]               usb_pll_input_divider_o,
  output logic                     sys_pll_input_select_o,
  output logic [4:0]               sys_pll_multiplier_o
);

  // Latched storage state
  cwd_pkg::cwd_store_t store_r, store_nxt;
  logic                loaded_r, loaded_nxt;
  // Runtime control copy
  logic                rt_bscan_r, rt_bscan_nxt;
  // Bus state
  logic                ack_r, ack_nxt;
  logic [31:0]         dat_r, dat_nxt;
  // Output registers
  cwd_pkg::cwd_cfg_t   cfg;
  cwd_pkg::cwd_cfg_t   cfg_r, cfg_nxt;
  logic                block_c;
  logic                block_r, block_nxt;

  cwd_field_dec u_dec (
    .store_i (store_r),
    .cfg_o   (cfg)
  );

  cwd_wp_guard u_guard (
    .prot_on_i  (cfg_r.prot_on),
    .prot_top_i (cfg_r.prot_top),
    .wr_req_i   (pfm_wr_req_i),
    .wr_addr_i  (pfm_wr_addr_i),
    .wr_block_o (block_c)
  );

  // Loader: words taken once after reset release
  always_comb begin
    store_nxt  = store_r;
    loaded_nxt = loaded_r;
    if (!loaded_r && store_valid_i) begin
      store_nxt  = store_i;
      loaded_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      store_r  <= '{word0: cwd_pkg::CWD_WORD_RST, word2: cwd_pkg::CWD_WORD_RST, code_protect: 1'b1};
      loaded_r <= 1'b0;
    end else begin
      store_r  <= store_nxt;
      loaded_r <= loaded_nxt;
    end
  end

  // Settings registered; safe defaults until loaded
  always_comb begin
    cfg_nxt      = cfg;
    rt_bscan_nxt = rt_bscan_r;
    block_nxt    = block_c;
    if (!loaded_r) begin
      cfg_nxt = cfg_r;
    end
    if (loaded_r && !loaded_o) begin
      rt_bscan_nxt = cfg.bscan_en;
    end else if (ack_r && wb_cyc_i && wb_stb_i && wb_we_i &&
                 wb_adr_i == cwd_pkg::CWD_OFS_RTCFG && wb_sel_i[0]) begin
      // Only writable bit; lands on the edge the master sees ack
      rt_bscan_nxt = wb_dat_i[0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r      <= '0;
      rt_bscan_r <= 1'b0;
      block_r    <= 1'b0;
    end else begin
      cfg_r      <= cfg_nxt;
      rt_bscan_r <= rt_bscan_nxt;
      block_r    <= block_nxt;
    end
  end

  // Loaded flag delayed so outputs align with cfg_r
  logic loaded_q_r;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loaded_q_r <= 1'b0;
    end else begin
      loaded_q_r <= loaded_r;
    end
  end

  // Wishbone read decode, one wait state
  always_comb begin
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    dat_nxt = dat_r;
    if (ack_nxt && !wb_we_i) begin
      if (wb_adr_i == cwd_pkg::CWD_OFS_CFG0) begin
        dat_nxt = store_r.word0;
      end else if (wb_adr_i == cwd_pkg::CWD_OFS_CFG2) begin
        dat_nxt = store_r.word2;
      end else if (wb_adr_i == cwd_pkg::CWD_OFS_PROT) begin
        dat_nxt = {cfg_r.prot_top[31:12], 2'h0, cfg_r.pwp_reserved, cfg_r.prot_on, cfg_r.prot_pages};
      end else if (wb_adr_i == cwd_pkg::CWD_OFS_CLK) begin
        dat_nxt = {5'h0, cfg_r.pll_mul, cfg_r.pll_src_frc, cfg_r.usb_idiv, cfg_r.usb_pll_on,
                   cfg_r.odiv, cfg_r.bor_en, cfg_r.vbbor_en, cfg_r.dsbor_en, 4'h0};
      end else if (wb_adr_i == cwd_pkg::CWD_OFS_RTCFG) begin
        dat_nxt = {31'h0, rt_bscan_r};
      end else if (wb_adr_i == cwd_pkg::CWD_OFS_STATUS) begin
        dat_nxt = {20'h0, cfg_r.pin_pair_onehot, cfg_r.dbg_field, cfg_r.dbg_en, cfg_r.bscan_en,
                   store_r.code_protect, cfg_r.rsv_ok, loaded_q_r, loaded_r};
      end else begin
        // Unmapped reads zero, still acknowledged
        dat_nxt = cwd_pkg::CWD_BUS_UNMAP;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // Registered outputs
  always_comb begin
    wb_ack_o                     = ack_r;
    wb_dat_o                     = dat_r;
    loaded_o                     = loaded_q_r;
    pfm_wr_block_o               = block_r;
    prog_pin_pair_o              = cfg_r.pin_pair_onehot;
    boundary_scan_enable_o       = rt_bscan_r;
    debug_enable_o               = cfg_r.dbg_en;
    deep_sleep_brownout_enable_o = cfg_r.dsbor_en;
    battery_brownout_enable_o    = cfg_r.vbbor_en;
    brownout_reset_enable_o      = cfg_r.bor_en;
    sys_pll_output_divisor_o     = cfg_r.odiv;
    usb_pll_enable_o             = cfg_r.usb_pll_on;
    usb_pll_input_divider_o      = cfg_r.usb_idiv;
    sys_pll_input_select_o       = cfg_r.pll_src_frc;
    sys_pll_multiplier_o         = cfg_r.pll_mul;
  end

endmodule : cwd_top

//--- logic/cwd_wp_guard.sv
// Program memory write-protect guard
module cwd_wp_guard (
  // Settings
  input  wire logic        prot_on_i,
  input  wire logic [31:0] prot_top_i,
  // Write attempt
  input  wire logic        wr_req_i,
  input  wire logic [31:0] wr_addr_i,
  // Result
  output logic             wr_block_o
);

  always_comb begin
    wr_block_o = wr_req_i & prot_on_i & (wr_addr_i >= cwd_pkg::CWD_PFM_BASE) & (wr_addr_i <= prot_top_i);
  end

endmodule : cwd_wp_guard

//--- testbench/cwd_top_props.sv
// Checker properties for the configuration word decoder
module cwd_top_props (
  // Clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  // Bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // Write guard
  input wire logic       pfm_wr_req_i,
  input wire logic       pfm_wr_block_o,
  // Settings
  input wire logic       loaded_o,
  input wire logic [3:0] prog_pin_pair_o,
  input wire logic [8:0] sys_pll_output_divisor_o,
  input wire logic [3:0] usb_pll_input_divider_o,
  input wire logic [4:0] sys_pll_multiplier_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_block_cause: assert property (pfm_wr_block_o |-> $past(pfm_wr_req_i))
    else $error("block without write");
  chk_pair_onehot: assert property (loaded_o |-> $onehot(prog_pin_pair_o))
    else $error("pin pair not one-hot");
  chk_odiv_legal: assert property (loaded_o |-> sys_pll_output_divisor_o inside
    {9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h100}) else $error("bad divisor");
  chk_idiv_legal: assert property (loaded_o |-> usb_pll_input_divider_o inside
    {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hc}) else $error("bad input divider");
  chk_mul_legal: assert property (loaded_o |-> sys_pll_multiplier_o inside
    {[5'h10:5'h15], 5'h18}) else $error("bad multiplier");
  chk_settings_held: assert property (loaded_o |=> loaded_o && $stable(sys_pll_multiplier_o))
    else $error("settings moved");

  cover property (wb_ack_o);
  cover property (pfm_wr_block_o);
  cover property ($rose(loaded_o));
endmodule : cwd_top_props

bind cwd_top cwd_top_props i_props (.mclk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pfm_wr_req_i,
  .pfm_wr_block_o, .loaded_o, .prog_pin_pair_o, .sys_pll_output_divisor_o, .usb_pll_input_divider_o,
  .sys_pll_multiplier_o);

//--- testbench/cwd_top_tb.sv
// Self-checking bench for the configuration word decoder
module cwd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                mclk_i = 0, rst_n_i = 0, store_valid_i = 0, pfm_wr_req_i = 0;
  logic                wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, loaded_o, blk;
  logic                bscan, dbg, ds, vb, bor, upll, src;
  logic [7:0]          wb_adr_i = 8'h00;
  logic [3:0]          wb_sel_i = 4'h0, pair, idiv;
  logic [8:0]          odiv;
  logic [4:0]          mul;
  logic [31:0]         wb_dat_i = 32'h0, wb_dat_o, pfm_wr_addr_i = 32'h0, q;
  cwd_pkg::cwd_store_t store_i = '0;
  logic [8:0]          odiv_tab [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h100};
  logic [3:0]          idiv_tab [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hc};
  logic [4:0]          mul_tab [8] = '{5'h10, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h18};
  int                  err_count = 0, total_checks = 0;

  initial forever #2 mclk_i = ~mclk_i;

  cwd_top i_dut (.mclk_i, .rst_n_i, .store_i, .store_valid_i, .pfm_wr_req_i, .pfm_wr_addr_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .loaded_o,
    .pfm_wr_block_o(blk), .prog_pin_pair_o(pair), .boundary_scan_enable_o(bscan), .debug_enable_o(dbg),
    .deep_sleep_brownout_enable_o(ds), .battery_brownout_enable_o(vb), .brownout_reset_enable_o(bor),
    .sys_pll_output_divisor_o(odiv), .usb_pll_enable_o(upll), .usb_pll_input_divider_o(idiv),
    .sys_pll_input_select_o(src), .sys_pll_multiplier_o(mul));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (n == 16) err_count++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic pfm(input logic [31:0] a, input logic exp);
    @(posedge mclk_i);
    pfm_wr_req_i <= 1'b1;
    pfm_wr_addr_i <= a;
    @(posedge mclk_i);
    pfm_wr_req_i <= 1'b0;
    #1 check(32'(blk), 32'(exp));
  endtask : pfm

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (5000) @(posedge mclk_i);
    err_count++;
    wrap_up();
  end

  initial begin
    logic [31:0] w0, w2, top;
    logic [7:0]  page_write_protect_count;
    logic [2:0]  c;
    logic        cp;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      // Code protect only where debug field would enable
      cp = (i == 4);
      page_write_protect_count = (i == 7) ? 8'hbf : 8'hff - 8'(i);
      w0 = {12'hfff, page_write_protect_count, 7'h7f, c[1:0], c[0], c[1:0]};
      w2 = {8'hff, c[0], 1'b1, c[1], c[2], 1'b1, c, c[0], 4'hf, c, c[1], c, 4'hf};
      rst_n_i <= 1'b0;
      store_valid_i <= 1'b0;
      store_i <= {w0, w2, cp};
      repeat (4) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      store_valid_i <= 1'b1;
      for (int n = 0; n < 10 && loaded_o !== 1'b1; n++) @(posedge mclk_i);
      check(32'(loaded_o), 32'h1);
      store_i <= ~{w0, w2, cp};
      repeat (2) @(posedge mclk_i);
      check(32'(pair), 32'(4'h8 >> c[1:0]));
      check(32'(bscan), 32'(c[0]));
      check(32'(dbg), 32'(!c[1] && !cp));
      check(32'({ds, vb, bor}), 32'({c[0], c[1], c[2]}));
      check(32'(odiv), 32'(odiv_tab[i]));
      check(32'(upll), 32'(!c[0]));
      check(32'(idiv), 32'(idiv_tab[i]));
      check(32'(src), 32'(c[1]));
      check(32'(mul), 32'(mul_tab[i]));
      top = 32'hbd00_0000 + {12'h000, ~page_write_protect_count, 12'h000};
      pfm(top - 32'h4, page_write_protect_count != 8'hff);
      pfm(top, 1'b0);
      wb(1'b1, 8'h00, ~w0);
      wb(1'b0, 8'h00, 32'h0);
      check(q, w0);
      wb(1'b0, 8'h0c, 32'h0);
      check(q, {5'h0, mul_tab[i], c[1], idiv_tab[i], !c[0], odiv_tab[i], c[2], c[1], c[0], 4'h0});
      wb(1'b0, 8'h10, 32'h0);
      check(32'(q[0]), 32'(c[0]));
      wb(1'b1, 8'h10, 32'(!c[0]));
      wb(1'b0, 8'h10, 32'h0);
      check(32'(q[0]), 32'(!c[0]));
      check(32'(bscan), 32'(!c[0]));
      wb(1'b0, 8'h14, 32'h0);
      check(32'(q[7:6]), cp ? 32'h3 : 32'(c[1:0]));
      wb(1'b0, 8'h18, 32'h0);
      check(q, 32'h0);
    end
    wrap_up();
  end
endmodule : cwd_top_tb
